// *** shared/ths_pkg.sv ***
// constants and types for the host-driven touch scan and auxiliary sequencer
package ths_pkg;
	// ==================================================================
	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DRV  = 8'h04;
	localparam logic [7:0] OFS_TIM0 = 8'h08;
	localparam logic [7:0] OFS_TIM1 = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_RES0 = 8'h14;	// results x,y,z1,z2,aux,t1,t2
	localparam int         NUM_RES  = 7;
	// ==================================================================
	// control register fields
	localparam int CTRL_TREQ_BIT = 0;	// touch_request_output_setting
	localparam int CTRL_FN_LSB   = 3;	// function select, bits 6..3
	localparam int CTRL_HOST_BIT = 7;	// host_driven_scan_mode
	localparam int TIM1_B12_BIT  = 7;	// 1: 12-bit, 0: 10-bit
	// ==================================================================
	// converter function codes
	localparam logic [3:0] FN_X     = 4'h2;
	localparam logic [3:0] FN_Y     = 4'h3;
	localparam logic [3:0] FN_Z     = 4'h4;
	localparam logic [3:0] FN_AUX   = 4'h5;
	localparam logic [3:0] FN_DIE_SENSOR_FIRST_METHOD = 4'h6;
	localparam logic [3:0] FN_DIE_SENSOR_SECOND_METHOD = 4'h7;
	localparam logic [3:0] FN_CONT  = 4'h8;
	// result slots
	localparam logic [2:0] RS_X = 3'h0;
	localparam logic [2:0] RS_Z1 = 3'h2;
	localparam logic [2:0] RS_Z2 = 3'h3;
	localparam logic [2:0] RS_AUX = 3'h4;
	localparam logic [2:0] RS_T1 = 3'h5;
	localparam logic [2:0] RS_T2 = 3'h6;
	// ==================================================================
	// start overheads in tenths of an oscillator cycle, the others in whole cycles, all counted in half cycles
	localparam int XY_START_X10    = 25;	// xy_start_overhead
	localparam int PRESS_START_X10 = 35;	// pressure_start_overhead
	localparam int MEAS_START_X10  = 35;	// measure_start_overhead
	localparam int THREE_PHASE_CYC = 10;	// three_phase_delay_overhead
	localparam int TWO_PHASE_CYC   = 6;	// two_phase_delay_overhead
	localparam int PER_CONV_CYC    = 3;	// per_conversion_overhead
	localparam int B_EXTRA         = 2;	// converter clocks beyond B
	localparam logic [15:0] HT_XY    = 16'(XY_START_X10 / 5);
	localparam logic [15:0] HT_PRESS = 16'(PRESS_START_X10 / 5);
	localparam logic [15:0] HT_MEAS  = 16'(MEAS_START_X10 / 5);
	localparam logic [15:0] HT_DLY3  = 16'(THREE_PHASE_CYC * 2);
	localparam logic [15:0] HT_DLY2  = 16'(TWO_PHASE_CYC * 2);
	localparam logic [15:0] HT_CONVO = 16'(PER_CONV_CYC * 2);
	localparam logic [4:0]  BITS12   = 5'd12;
	localparam logic [4:0]  BITS10   = 5'd10;
	// ==================================================================
	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_START  = 8'h02,
		ST_SETTLE = 8'h04,
		ST_PRE    = 8'h08,
		ST_SNS    = 8'h10,
		ST_DLY    = 8'h20,
		ST_CONV   = 8'h40,
		ST_PPRO   = 8'h80
	} ths_state_t;
endpackage

// *** rtl/ths_sequencer.sv ***
// host-driven touch scan, auxiliary and die sensor conversion sequencer
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module ths_sequencer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        osc_clk,
	input  wire logic        pen_touch,
	input  wire logic [11:0] adc_data,
	output logic             touch_or_result_ready_pin_n,
	output logic             panel_drivers_on,
	output logic             scan_busy
);
	// ==================================================================
	// input synchronisers
	logic        osc_s1_ff, osc_s2_ff, osc_s3_ff;
	logic        pen_s1_ff, pen_s2_ff;
	logic [11:0] adc_s1_ff, adc_s2_ff;
	logic        tick;

	// every pin passes two flops; osc_s3 only remembers the last level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_s1_ff <= 1'b0;
			osc_s2_ff <= 1'b0;
			osc_s3_ff <= 1'b0;
			pen_s1_ff <= 1'b0;
			pen_s2_ff <= 1'b0;
			adc_s1_ff <= 12'h000;
			adc_s2_ff <= 12'h000;
		end else begin
			osc_s1_ff <= osc_clk;
			osc_s2_ff <= osc_s1_ff;
			osc_s3_ff <= osc_s2_ff;
			pen_s1_ff <= pen_touch;
			pen_s2_ff <= pen_s1_ff;
			adc_s1_ff <= adc_data;
			adc_s2_ff <= adc_s1_ff;
		end
	end
	// both edges count: half cycles let 2.5 and 3.5 land exactly
	assign tick = osc_s2_ff ^ osc_s3_ff;

	// ==================================================================
	// apb register file
	logic        ctrl_treq_ff, ctrl_host_ff, drv_on_ff, settle_ff, avail_ff, b12_ff;
	logic [3:0]  ctrl_fn_ff;
	logic [31:0] tim0_ff;
	logic [4:0]  nconv_ff;
	logic [7:0]  ppro_ff;
	logic [15:0] res_ff [ths_pkg::NUM_RES];
	logic        setup, wr_fire, rd_fire, wr_ctrl;
	logic        mapped;
	logic [3:0]  wr_fn;
	logic [31:0] rd_val;

	assign setup   = psel && !penable;
	assign wr_fire = psel && penable && pwrite && pready;
	assign rd_fire = psel && penable && !pwrite && pready;
	assign wr_ctrl = wr_fire && (paddr == ths_pkg::OFS_CTRL);
	assign wr_fn   = pwdata[ths_pkg::CTRL_FN_LSB +: 4];

	// read mux, decoded in the setup cycle so data comes from a flop
	always_comb begin
		rd_val = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			ths_pkg::OFS_CTRL: begin
				rd_val[ths_pkg::CTRL_TREQ_BIT] = ctrl_treq_ff;
				rd_val[ths_pkg::CTRL_FN_LSB +: 4] = ctrl_fn_ff;
				rd_val[ths_pkg::CTRL_HOST_BIT] = ctrl_host_ff;
			end
			ths_pkg::OFS_DRV:  rd_val[0] = drv_on_ff;
			ths_pkg::OFS_TIM0: rd_val = tim0_ff;
			ths_pkg::OFS_TIM1: rd_val = {16'h0000, ppro_ff, b12_ff, 2'b00, nconv_ff};
			ths_pkg::OFS_STAT: rd_val = {28'h0000000, pen_s2_ff, avail_ff,
				scan_busy, drv_on_ff};
			default: begin
				if (paddr >= ths_pkg::OFS_RES0 && paddr[1:0] == 2'b00 &&
				    paddr < ths_pkg::OFS_RES0 + 8'(4 * ths_pkg::NUM_RES))
					rd_val = {16'h0000, res_ff[3'((paddr - ths_pkg::OFS_RES0) >> 2)]};
				else
					mapped = 1'b0;
			end
		endcase
	end

	// zero-wait slave: answer stands in the access cycle only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
		end
	end

	// configuration writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_treq_ff <= 1'b1;
			ctrl_host_ff <= 1'b1;
			ctrl_fn_ff   <= 4'h0;
			tim0_ff      <= 32'h0101_0101;
			nconv_ff     <= 5'h01;
			b12_ff       <= 1'b1;
			ppro_ff      <= 8'h02;
		end else if (wr_fire && !pslverr) begin
			case (paddr)
				ths_pkg::OFS_CTRL: begin
					ctrl_treq_ff <= pwdata[ths_pkg::CTRL_TREQ_BIT];
					ctrl_fn_ff   <= wr_fn;
					ctrl_host_ff <= pwdata[ths_pkg::CTRL_HOST_BIT];
				end
				ths_pkg::OFS_TIM0: tim0_ff <= pwdata;
				ths_pkg::OFS_TIM1: begin
					nconv_ff <= (pwdata[4:0] == 5'h00) ? 5'h01 : pwdata[4:0];
					b12_ff   <= pwdata[ths_pkg::TIM1_B12_BIT];
					ppro_ff  <= pwdata[15:8];
				end
				default: ;
			endcase
		end
	end

	// ==================================================================
	// sequencer
	ths_pkg::ths_state_t state_ff, nxt_state;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [3:0]  kind_ff;
	logic [4:0]  idx_ff;
	logic        zsec_ff, done, start_go, cont_go, is_scan, is_meas, scan_code;
	logic [11:0] last_ff;
	logic [2:0]  slot;
	logic [15:0] conv_ht;

	// one conversion: (B+2) converter clocks plus fixed overhead
	assign conv_ht = 16'((((b12_ff ? ths_pkg::BITS12 : ths_pkg::BITS10) +
		5'(ths_pkg::B_EXTRA)) * tim0_ff[31:24]) * 2) + ths_pkg::HT_CONVO;
	assign done = tick && (cnt_ff <= 16'h0001);
	assign scan_code = (wr_fn == ths_pkg::FN_X) || (wr_fn == ths_pkg::FN_Y) ||
		(wr_fn == ths_pkg::FN_Z);
	assign is_scan = (kind_ff == ths_pkg::FN_X) || (kind_ff == ths_pkg::FN_Y) ||
		(kind_ff == ths_pkg::FN_Z);
	assign is_meas = !is_scan;
	// nothing starts without a code write, except the continuous loop
	assign start_go = wr_ctrl && ((scan_code && pwdata[ths_pkg::CTRL_HOST_BIT]) ||
		(wr_fn == ths_pkg::FN_AUX) || (wr_fn == ths_pkg::FN_DIE_SENSOR_FIRST_METHOD) ||
		(wr_fn == ths_pkg::FN_DIE_SENSOR_SECOND_METHOD) || (wr_fn == ths_pkg::FN_CONT));
	assign cont_go = (ctrl_fn_ff == ths_pkg::FN_CONT) && !psel && !wr_ctrl;

	// result slot for the finishing conversion
	always_comb begin
		case (kind_ff)
			ths_pkg::FN_X:     slot = ths_pkg::RS_X;
			ths_pkg::FN_Y:     slot = ths_pkg::RS_X + 3'h1;
			ths_pkg::FN_Z:     slot = zsec_ff ? ths_pkg::RS_Z2 : ths_pkg::RS_Z1;
			ths_pkg::FN_DIE_SENSOR_FIRST_METHOD: slot = ths_pkg::RS_T1;
			ths_pkg::FN_DIE_SENSOR_SECOND_METHOD: slot = ths_pkg::RS_T2;
			default:           slot = ths_pkg::RS_AUX;
		endcase
	end

	// phase order and lengths in half oscillator cycles
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = (tick && cnt_ff != 16'h0000) ? cnt_ff - 16'h0001 : cnt_ff;
		case (state_ff)
			ths_pkg::ST_IDLE: begin
				if (start_go || cont_go) begin
					nxt_state = ths_pkg::ST_START;
					if (start_go && scan_code)
						nxt_cnt = (wr_fn == ths_pkg::FN_Z) ? ths_pkg::HT_PRESS :
							ths_pkg::HT_XY;
					else
						nxt_cnt = ths_pkg::HT_MEAS;
				end
			end
			ths_pkg::ST_START: if (done) begin
				// measurements skip settle, precharge and sense
				if (is_meas) begin
					nxt_state = ths_pkg::ST_CONV;
					nxt_cnt   = conv_ht;
				end else if (settle_ff) begin
					nxt_state = ths_pkg::ST_SETTLE;
					nxt_cnt   = {7'h00, tim0_ff[7:0], 1'b0};
				end else begin
					nxt_state = ths_pkg::ST_PRE;
					nxt_cnt   = {7'h00, tim0_ff[15:8], 1'b0};
				end
			end
			ths_pkg::ST_SETTLE: if (done) begin
				nxt_state = ths_pkg::ST_PRE;
				nxt_cnt   = {7'h00, tim0_ff[15:8], 1'b0};
			end
			ths_pkg::ST_PRE: if (done) begin
				nxt_state = ths_pkg::ST_SNS;
				nxt_cnt   = {7'h00, tim0_ff[23:16], 1'b0};
			end
			ths_pkg::ST_SNS: if (done) begin
				nxt_state = ths_pkg::ST_DLY;
				nxt_cnt   = settle_ff ? ths_pkg::HT_DLY3 : ths_pkg::HT_DLY2;
			end
			ths_pkg::ST_DLY: if (done) begin
				nxt_state = ths_pkg::ST_CONV;
				nxt_cnt   = conv_ht;
			end
			ths_pkg::ST_CONV: if (done) begin
				if (idx_ff + 5'h01 >= nconv_ff) begin
					nxt_state = ths_pkg::ST_PPRO;
					nxt_cnt   = {7'h00, ppro_ff, 1'b0};
				end else
					nxt_cnt = conv_ht;
			end
			ths_pkg::ST_PPRO: if (done) begin
				// pressure carries on with its second value in the same scan
				if (kind_ff == ths_pkg::FN_Z && !zsec_ff) begin
					nxt_state = ths_pkg::ST_CONV;
					nxt_cnt   = conv_ht;
				end else
					nxt_state = ths_pkg::ST_IDLE;
			end
			default: nxt_state = ths_pkg::ST_IDLE;
		endcase
	end

	// state and phase counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ths_pkg::ST_IDLE;
			cnt_ff   <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	// scan bookkeeping: kind, conversion index, second pressure value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kind_ff <= 4'h0;
			idx_ff  <= 5'h00;
			zsec_ff <= 1'b0;
			last_ff <= 12'h000;
		end else begin
			if (state_ff == ths_pkg::ST_IDLE && start_go)
				kind_ff <= wr_fn;
			else if (state_ff == ths_pkg::ST_IDLE && cont_go)
				kind_ff <= ths_pkg::FN_CONT;
			if (state_ff == ths_pkg::ST_IDLE)
				zsec_ff <= 1'b0;
			else if (state_ff == ths_pkg::ST_PPRO && done)
				zsec_ff <= 1'b1;
			if (state_ff == ths_pkg::ST_CONV && done) begin
				last_ff <= adc_s2_ff;
				idx_ff  <= (nxt_state == ths_pkg::ST_CONV) ? idx_ff + 5'h01 : 5'h00;
			end
		end
	end

	// drivers: host command, or self-enabled with extra settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_on_ff <= 1'b0;
			settle_ff <= 1'b0;
		end else begin
			if (state_ff == ths_pkg::ST_IDLE && start_go && scan_code) begin
				drv_on_ff <= 1'b1;
				settle_ff <= !drv_on_ff;
			end else if (wr_fire && paddr == ths_pkg::OFS_DRV)
				drv_on_ff <= pwdata[0];
		end
	end

	// results land at the end of preprocessing; data-ready is sticky
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < ths_pkg::NUM_RES; i++)
				res_ff[i] <= 16'h0000;
			avail_ff <= 1'b0;
		end else begin
			if (state_ff == ths_pkg::ST_PPRO && done)
				res_ff[slot] <= {4'h0, last_ff};
			// a result finishing in the clearing read still wins
			if (state_ff == ths_pkg::ST_PPRO && done)
				avail_ff <= 1'b1;
			else if (rd_fire && paddr == ths_pkg::OFS_STAT)
				avail_ff <= 1'b0;
		end
	end

	// ==================================================================
	// pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			touch_or_result_ready_pin_n <= 1'b1;
			panel_drivers_on            <= 1'b0;
			scan_busy                   <= 1'b0;
		end else begin
			touch_or_result_ready_pin_n <= ctrl_treq_ff ? !pen_s2_ff : !avail_ff;
			panel_drivers_on            <= drv_on_ff;
			scan_busy                   <= (nxt_state != ths_pkg::ST_IDLE);
		end
	end

	// ==================================================================
	// checks
	sequence s_last_tick;
		done;
	endsequence

	chk_pin_touch: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_treq_ff && pen_s2_ff |=> !touch_or_result_ready_pin_n)
		else $error("touch did not lower the pin");
	chk_no_auto: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_IDLE && !start_go && !cont_go |=>
		state_ff == ths_pkg::ST_IDLE)
		else $error("scan began without a command");
	chk_self_drive: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_IDLE && start_go && scan_code && !drv_on_ff |=>
		drv_on_ff && settle_ff && state_ff == ths_pkg::ST_START)
		else $error("drivers not enabled for scan");
	chk_dly_len: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_DLY && $past(state_ff) == ths_pkg::ST_SNS |->
		cnt_ff == (settle_ff ? 16'h0014 : 16'h000C))
		else $error("delay overhead wrong");
	chk_start_len: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_START && $past(state_ff) == ths_pkg::ST_IDLE |->
		cnt_ff == (kind_ff == ths_pkg::FN_X || kind_ff == ths_pkg::FN_Y ? 16'h0005 :
		16'h0007))
		else $error("start overhead wrong");
	chk_meas_skip: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_START && is_meas ##0 s_last_tick |=>
		state_ff == ths_pkg::ST_CONV)
		else $error("measurement entered panel phases");
	chk_settle_path: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_START && is_scan && settle_ff ##0 s_last_tick |=>
		state_ff == ths_pkg::ST_SETTLE)
		else $error("settle phase skipped");
	chk_conv_len: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_CONV && $past(state_ff) != ths_pkg::ST_CONV |->
		cnt_ff == conv_ht && conv_ht >= 16'h0006)
		else $error("conversion length wrong");
	chk_press_two: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_PPRO && kind_ff == ths_pkg::FN_Z && !zsec_ff && done |=>
		state_ff == ths_pkg::ST_CONV && zsec_ff)
		else $error("second pressure value missing");
	chk_result_store: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_PPRO && done |=>
		res_ff[$past(slot)] == {4'h0, $past(last_ff)} && avail_ff)
		else $error("result not stored");
	chk_code_start: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_IDLE && wr_ctrl && (wr_fn == ths_pkg::FN_AUX ||
		wr_fn == ths_pkg::FN_DIE_SENSOR_FIRST_METHOD || wr_fn == ths_pkg::FN_DIE_SENSOR_SECOND_METHOD) |=>
		state_ff == ths_pkg::ST_START && cnt_ff == 16'h0007)
		else $error("measurement code did not start");
	chk_cont_loop: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == ths_pkg::ST_IDLE && ctrl_fn_ff == ths_pkg::FN_CONT && !psel |=>
		state_ff == ths_pkg::ST_START)
		else $error("continuous measurement stalled");
endmodule

`default_nettype wire

// *** sim/ths_front_end_model.sv ***
// oscillator, touch panel and converter stand-in facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module ths_front_end_model (
	input  wire logic        touched,
	input  wire logic [11:0] level,
	output logic             osc_clk,
	output logic             pen_touch,
	output logic      [11:0] adc_data
);
	// ==========
	// free-running oscillator, 80 ns period, unrelated in phase to pclk
	initial begin
		osc_clk = 1'b0;
		forever #40 osc_clk = ~osc_clk;
	end
	// panel contact and converted level follow what the bench sets up
	assign pen_touch = touched;
	assign adc_data  = level;
endmodule
`default_nettype wire

// *** sim/ths_sequencer_tb_top.sv ***
// self-checking bench for the host-driven scan and measurement sequencer
`timescale 1ns/1ns
`default_nettype none
module ths_sequencer_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, touched;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, osc_clk, pen_touch, pin_n, drv_on, busy;
	logic [11:0] level, adc_data;
	int          mismatches, samples_checked;
	// ==========
	// half osc ticks at reset timing: 1-cycle settle/precharge/sense, N 1, 12 bits, latency 2
	localparam int CP_T = 2 * (12 + ths_pkg::B_EXTRA + ths_pkg::PER_CONV_CYC) + 4;
	localparam int MEAS_T = int'(ths_pkg::HT_MEAS) + CP_T;
	localparam int XY_ON_T = int'(ths_pkg::HT_XY) + 4 + int'(ths_pkg::HT_DLY2) + CP_T;
	localparam int XY_OFF_T = int'(ths_pkg::HT_XY) + 6 + int'(ths_pkg::HT_DLY3) + CP_T;
	localparam int Z_T = int'(ths_pkg::HT_PRESS) + 4 + int'(ths_pkg::HT_DLY2) + 2 * CP_T;
	// ==========
	ths_sequencer i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_clk(osc_clk),
		.pen_touch(pen_touch), .adc_data(adc_data),
		.touch_or_result_ready_pin_n(pin_n), .panel_drivers_on(drv_on),
		.scan_busy(busy)
	);
	ths_front_end_model i_fe (
		.touched(touched), .level(level), .osc_clk(osc_clk),
		.pen_touch(pen_touch), .adc_data(adc_data)
	);
	// 100 MHz system clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ==========
	// compares and the single closing point
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// slack covers the oscillator's unknown phase and its synchroniser
	task automatic check_near(input string what, input int exp, input int got);
		samples_checked++;
		if (got < exp - 8 || got > exp + 8) begin
			mismatches++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic timed_out(input string what);
		mismatches++;
		$display("MISMATCH %s expected answer seen timeout", what);
		tally_and_finish();
	endtask
	// ==========
	// apb transfer; a free edge first so psel is never assigned twice in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// answer is looked at mid-cycle, where it has settled
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) timed_out("pready");
		rd = prdata;
		err = pslverr;
		// the completing edge, then release
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
		check_val("write error flag", 32'h0, {31'h0, e});
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 32'h0, rd, e);
		check_val(what, exp, rd);
	endtask
	function automatic logic [7:0] res_ofs(input logic [2:0] s);
		return ths_pkg::OFS_RES0 + {3'h0, s, 2'h0};
	endfunction
	// launch a function and count the cycles the sequencer stays busy
	task automatic run_fn(input logic [31:0] ctrl, output int len);
		int n;
		wr(ths_pkg::OFS_CTRL, ctrl);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (busy !== 1'b1 && n < 20);
		if (n >= 20) timed_out("busy rise");
		len = 0;
		while (busy === 1'b1 && len < 3000) begin
			@(negedge pclk);
			len++;
		end
		if (len >= 3000) timed_out("busy fall");
	endtask
	// ==========
	// reset values and an unmapped place
	task automatic t_reset_regs;
		logic [31:0] rd;
		logic        e;
		rd_chk("ctrl reset", ths_pkg::OFS_CTRL, 32'h81);
		rd_chk("drv reset", ths_pkg::OFS_DRV, 32'h0);
		rd_chk("tim0 reset", ths_pkg::OFS_TIM0, 32'h01010101);
		rd_chk("tim1 reset", ths_pkg::OFS_TIM1, 32'h281);
		rd_chk("aux reset", res_ofs(ths_pkg::RS_AUX), 32'h0);
		apb(1'b0, 8'h40, 32'h0, rd, e);
		check_val("unmapped error", 32'h1, {31'h0, e});
		check_val("unmapped data", 32'h0, rd);
	endtask
	// touch lowers the pin but starts nothing by itself
	task automatic t_touch;
		touched <= 1'b1;
		repeat (5) @(posedge pclk);
		check_val("pin on touch", 32'h0, {31'h0, pin_n});
		check_val("no auto scan", 32'h0, {31'h0, busy});
		touched <= 1'b0;
		repeat (5) @(posedge pclk);
		check_val("pin released", 32'h1, {31'h0, pin_n});
	endtask
	// coordinate and pressure scans, drivers first off then enabled by the host
	task automatic t_scan;
		int len;
		wr(ths_pkg::OFS_CTRL, 32'h10);
		repeat (10) @(posedge pclk);
		check_val("scan outside host mode", 32'h0, {31'h0, busy});
		level <= 12'h2AB;
		run_fn(32'h90, len);
		check_near("x self-enabled time", XY_OFF_T * 4, len);
		check_val("drivers turned on", 32'h1, {31'h0, drv_on});
		rd_chk("x result", res_ofs(ths_pkg::RS_X), 32'h2AB);
		wr(ths_pkg::OFS_DRV, 32'h1);
		repeat (20) @(posedge pclk);
		level <= 12'h3CD;
		run_fn(32'h98, len);
		check_near("y time", XY_ON_T * 4, len);
		rd_chk("y result", res_ofs(3'h1), 32'h3CD);
		level <= 12'h0EF;
		run_fn(32'hA0, len);
		check_near("pressure time", Z_T * 4, len);
		rd_chk("z1 result", res_ofs(ths_pkg::RS_Z1), 32'hEF);
		rd_chk("z2 result", res_ofs(ths_pkg::RS_Z2), 32'hEF);
	endtask
	// single auxiliary and both die sensor measurements
	task automatic t_measure;
		logic [31:0] ctl [3] = '{32'hA8, 32'hB0, 32'hB8};
		logic [2:0]  slot [3] = '{ths_pkg::RS_AUX, ths_pkg::RS_T1, ths_pkg::RS_T2};
		int          len, aux_len;
		wr(ths_pkg::OFS_DRV, 32'h0);
		for (int i = 0; i < 3; i++) begin
			level <= 12'h100 + 12'(i);
			run_fn(ctl[i], len);
			if (i == 0) aux_len = len;
			check_near("measure time", MEAS_T * 4, len);
			check_near("same as aux", aux_len, len);
			rd_chk("measure result", res_ofs(slot[i]), 32'h100 + 32'(i));
			check_val("drivers left off", 32'h0, {31'h0, drv_on});
		end
		check_val("result ready pin", 32'h0, {31'h0, pin_n});
		rd_chk("status", ths_pkg::OFS_STAT, 32'h4);
		repeat (3) @(posedge pclk);
		check_val("ready pin cleared", 32'h1, {31'h0, pin_n});
	endtask
	// count scan starts over a span with the bus idle
	task automatic count_rises(input int span, output int rises);
		logic prev;
		rises = 0;
		prev = 1'b0;
		repeat (span) begin
			@(negedge pclk);
			if (busy === 1'b1 && prev === 1'b0) rises++;
			prev = busy;
		end
	endtask
	// continuous auxiliary runs until another function is written
	task automatic t_continuous;
		int rises;
		level <= 12'h5A5;
		wr(ths_pkg::OFS_CTRL, 32'hC0);
		count_rises(800, rises);
		check_val("keeps repeating", 32'h1, {31'h0, rises >= 3});
		level <= 12'h3C3;
		repeat (400) @(posedge pclk);
		rd_chk("fresh aux", res_ofs(ths_pkg::RS_AUX), 32'h3C3);
		wr(ths_pkg::OFS_CTRL, 32'h80);
		repeat (300) @(posedge pclk);
		count_rises(400, rises);
		check_val("stopped", 32'h0, 32'(rises));
	endtask
	// ==========
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		touched = 1'b0;
		level = 12'h000;
		mismatches = 0;
		samples_checked = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_regs();
		t_touch();
		t_scan();
		t_measure();
		t_continuous();
		tally_and_finish();
	end
endmodule
`default_nettype wire
